// ===== test_regs_defines.svh
// Register map, field layout and reset constants of the integration-test registers
// Function
// - Control at 0xF00, input 0xF20, output 0xF40
// - Control bit 0 selects test operation
// - Either reset clears the test-select bit
// - Test-select steers the input multiplexors
// - Control bits 31:1 undefined, write zero
// - Every test register access has one wait
// - Input register has ten bits, rest undefined
// - Input read: stored if test, else pin
// - In test, writes set or clear input fields
// - Bit 9 legacy config, bit 8 byte-lane polarity
// - Bits 7 to 4 are chip-select polarities
// - Software drives intra-chip outputs through output register
// - Bits 3:2 width, 1 endianness, 0 refresh request
// - Output bit 1 high-voltage reset, bit 0 ack
`ifndef TEST_REGS_DEFINES_SVH
`define TEST_REGS_DEFINES_SVH

`define TR_OFF_W 12
`define TR_CTL_OFF 12'hF00
`define TR_TIN_OFF 12'hF20
`define TR_TOUT_OFF 12'hF40

`define TR_CTL_RST 1'h0
`define TR_TIN_RST 10'h000
`define TR_TOUT_RST 2'h0

`define TR_TEST_BIT 0
`define TR_TIN_MSB 9
`define TR_TOUT_MSB 1
`define TR_SACK_BIT 0
`define TR_HVR_BIT 1

`define TR_HTRANS_ACT_BIT 1
`define TR_HRESP_OKAY 2'h0
`define TR_WORD_ZERO 32'h0000_0000

`endif

// ===== test_regs_pkg.sv
// Types shared by the integration-test register block
`default_nettype none
package test_regs_pkg;

	// Bus phase; idle, wait state, then the closing data cycle
	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_WAIT = 2'b01,
		PH_LAST = 2'b11
	} phase_e;

	// Order matches test input register bits 9 down to 0
	typedef struct packed {
		logic       legacy_revision_config_in;
		logic       cs1_byte_lane_polarity_in;
		logic       cs3_polarity_in;
		logic       cs2_polarity_in;
		logic       cs1_polarity_in;
		logic       cs0_polarity_in;
		logic [1:0] cs1_memory_width_in;
		logic       endianness_select_in;
		logic       self_refresh_request_in;
	} test_in_s;

	// Order matches test output register bits 1 and 0
	typedef struct packed {
		logic high_voltage_reset_out;
		logic self_refresh_acknowledge_out;
	} test_out_s;

	typedef struct packed {
		phase_e      phase;
		logic [11:0] addr;
		logic        wr;
		logic        test;
		test_in_s    tin;
		test_out_s   tout;
		logic [31:0] rdata;
	} state_s;

endpackage : test_regs_pkg
`default_nettype wire

// ===== test_regs.sv
// Integration-test registers: control, input capture/override and output drive
`include "test_regs_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module test_regs (
	input  wire logic                     ref_clk,
	input  wire logic                     rst_n,
	input  wire logic                     power_on_reset_n,
	input  wire logic                     hsel,
	input  wire logic [1:0]               htrans,
	input  wire logic                     hwrite,
	input  wire logic [31:0]              haddr,
	input  wire logic [31:0]              hwdata,
	input  wire logic                     hready_in,
	output logic [31:0]                   hrdata,
	output logic                          hready_out,
	output logic [1:0]                    hresp,
	input  wire test_regs_pkg::test_in_s  pins_in,
	output test_regs_pkg::test_in_s       core_in,
	input  wire test_regs_pkg::test_out_s core_out,
	output test_regs_pkg::test_out_s      pins_out,
	output logic                          test_mode
);

	test_regs_pkg::state_s st;
	test_regs_pkg::state_s next_st;

	logic accept;
	logic commit;
	logic any_reset;

	// Read word for one register; unmapped and undefined bits read zero
	function automatic logic [31:0] rd_word(
		input logic [11:0]              a,
		input logic                     t,
		input test_regs_pkg::test_in_s  ti,
		input test_regs_pkg::test_out_s to
	);
		logic [31:0] w;
		w = `TR_WORD_ZERO;
		unique case (a)
			`TR_CTL_OFF: begin
				w[`TR_TEST_BIT] = t;
			end
			`TR_TIN_OFF: begin
				w[`TR_TIN_MSB:0] = ti;
			end
			`TR_TOUT_OFF: begin
				w[`TR_TOUT_MSB:0] = to;
			end
			default: begin
				w = `TR_WORD_ZERO;
			end
		endcase
		return w;
	endfunction : rd_word

	assign any_reset = !rst_n || !power_on_reset_n;

	// A request is only taken while no wait state is pending
	assign accept = hsel && htrans[`TR_HTRANS_ACT_BIT] && hready_in
		&& (st.phase != test_regs_pkg::PH_WAIT);

	assign commit = (st.phase == test_regs_pkg::PH_WAIT);

	// Input multiplexors: live pins in normal mode, stored values in test
	assign core_in = st.test ? st.tin : pins_in;

	// Output drive; functional path wins whenever test is off
	assign pins_out = st.test ? st.tout : core_out;

	assign test_mode = st.test;
	assign hrdata = st.rdata;
	assign hready_out = (st.phase != test_regs_pkg::PH_WAIT);
	assign hresp = `TR_HRESP_OKAY;

	always_comb begin
		next_st = st;
		unique case (st.phase)
			test_regs_pkg::PH_IDLE: begin
				next_st.phase = test_regs_pkg::PH_IDLE;
			end
			test_regs_pkg::PH_WAIT: begin
				// Write data is sampled in the wait cycle, where it is already stable
				next_st.phase = test_regs_pkg::PH_LAST;
				if (st.wr) begin
					unique case (st.addr)
						`TR_CTL_OFF: begin
							next_st.test = hwdata[`TR_TEST_BIT];
						end
						`TR_TIN_OFF: begin
							if (st.test) begin
								next_st.tin = hwdata[`TR_TIN_MSB:0];
							end
						end
						`TR_TOUT_OFF: begin
							if (st.test) begin
								next_st.tout = hwdata[`TR_TOUT_MSB:0];
							end
						end
						default: begin
							next_st.test = st.test;
						end
					endcase
				end else begin
					next_st.rdata = rd_word(st.addr, st.test, core_in, pins_out);
				end
			end
			test_regs_pkg::PH_LAST: begin
				next_st.phase = test_regs_pkg::PH_IDLE;
			end
			default: begin
				next_st.phase = test_regs_pkg::PH_IDLE;
			end
		endcase
		if (accept) begin
			next_st.phase = test_regs_pkg::PH_WAIT;
			next_st.addr = haddr[`TR_OFF_W-1:0];
			next_st.wr = hwrite;
		end
		if (any_reset) begin
			next_st.phase = test_regs_pkg::PH_IDLE;
			next_st.addr = `TR_CTL_OFF;
			next_st.wr = 1'b0;
			next_st.test = `TR_CTL_RST;
			next_st.tin = `TR_TIN_RST;
			next_st.tout = `TR_TOUT_RST;
			next_st.rdata = `TR_WORD_ZERO;
		end
	end

	always_ff @(posedge ref_clk) begin
		st <= next_st;
	end

	chk_reset_clears_test: assert property (
		@(posedge ref_clk) !power_on_reset_n |=> !test_mode
	) else $error("test select not cleared by power-on reset");

	chk_one_wait_state: assert property (
		@(posedge ref_clk) disable iff (any_reset)
		accept |=> !hready_out ##1 hready_out
	) else $error("test register access did not take one wait state");

	chk_ctl_write_sets: assert property (
		@(posedge ref_clk) disable iff (any_reset)
		(accept && hwrite && haddr[`TR_OFF_W-1:0] == `TR_CTL_OFF)
		##1 1'b1 |=> test_mode == $past(hwdata[`TR_TEST_BIT])
	) else $error("control write did not update test select");

	chk_tin_read_stored: assert property (
		@(posedge ref_clk) disable iff (any_reset)
		(commit && !st.wr && st.test && st.addr == `TR_TIN_OFF)
		|=> hrdata[`TR_TIN_MSB:0] == $past(st.tin)
	) else $error("input register read in test did not return stored value");

	chk_tin_read_live: assert property (
		@(posedge ref_clk) disable iff (any_reset)
		(commit && !st.wr && !st.test && st.addr == `TR_TIN_OFF)
		|=> hrdata[`TR_TIN_MSB:0] == $past(pins_in)
	) else $error("input register read in normal mode did not return pins");

	chk_tin_write_blocked: assert property (
		@(posedge ref_clk) disable iff (any_reset)
		(commit && st.wr && !st.test && st.addr == `TR_TIN_OFF)
		|=> $stable(st.tin)
	) else $error("input register changed outside test");

	chk_tin_write_taken: assert property (
		@(posedge ref_clk) disable iff (any_reset)
		(commit && st.wr && st.test && st.addr == `TR_TIN_OFF)
		|=> st.tin == $past(hwdata[`TR_TIN_MSB:0])
	) else $error("input register write in test not stored");

	chk_out_test_drive: assert property (
		@(posedge ref_clk) disable iff (any_reset)
		(commit && st.wr && st.test && st.addr == `TR_TOUT_OFF)
		|=> pins_out == $past(hwdata[`TR_TOUT_MSB:0])
	) else $error("output pins not driven from output register");

	chk_out_functional: assert property (
		@(posedge ref_clk) disable iff (any_reset)
		!test_mode |-> pins_out == core_out
	) else $error("functional outputs overridden outside test");

	chk_in_mux_normal: assert property (
		@(posedge ref_clk) disable iff (any_reset)
		!test_mode |-> core_in == pins_in
	) else $error("core does not see live pins in normal mode");

	chk_unmapped_zero: assert property (
		@(posedge ref_clk) disable iff (any_reset)
		(commit && !st.wr && st.addr != `TR_CTL_OFF
		&& st.addr != `TR_TIN_OFF && st.addr != `TR_TOUT_OFF)
		|=> hrdata == `TR_WORD_ZERO
	) else $error("unmapped read returned nonzero data");

	// Bus reset alone must clear the select as well as power-on reset
	chk_bus_reset_clears: assert property (
		@(posedge ref_clk)
		!rst_n |=> !test_mode
	) else $error("test select not cleared by bus reset");

	chk_reset_clears_regs: assert property (
		@(posedge ref_clk)
		any_reset |=> st.tin == `TR_TIN_RST && st.tout == `TR_TOUT_RST
	) else $error("test registers not cleared by reset");

	chk_ready_after_reset: assert property (
		@(posedge ref_clk)
		any_reset |=> hready_out && hrdata == `TR_WORD_ZERO
	) else $error("bus not idle after reset");

	chk_por_restores_outputs: assert property (
		@(posedge ref_clk)
		!power_on_reset_n |=> pins_out == core_out
	) else $error("functional outputs not restored by power-on reset");

	chk_hresp_okay: assert property (
		@(posedge ref_clk)
		hresp == `TR_HRESP_OKAY
	) else $error("error response on a test register access");

	chk_wait_single: assert property (
		@(posedge ref_clk) disable iff (any_reset)
		!hready_out |=> hready_out
	) else $error("wait state lasted more than one cycle");

	chk_accept_ready: assert property (
		@(posedge ref_clk) disable iff (any_reset)
		accept |-> hready_out
	) else $error("request taken while a wait state was pending");

	chk_commit_then_ready: assert property (
		@(posedge ref_clk) disable iff (any_reset)
		commit |=> hready_out
	) else $error("access did not complete after its wait state");

	// Read data must stand until the next read finishes
	chk_write_keeps_rdata: assert property (
		@(posedge ref_clk) disable iff (any_reset)
		commit && st.wr |=> $stable(hrdata)
	) else $error("write disturbed the read data");

	chk_ctl_write_any: assert property (
		@(posedge ref_clk) disable iff (any_reset)
		commit && st.wr && st.addr == `TR_CTL_OFF |=> test_mode == $past(hwdata[`TR_TEST_BIT])
	) else $error("control write not taken");

	chk_ctl_read_value: assert property (
		@(posedge ref_clk) disable iff (any_reset)
		commit && !st.wr && st.addr == `TR_CTL_OFF |=> hrdata[`TR_TEST_BIT] == $past(st.test)
	) else $error("control read returned wrong select");

	chk_ctl_upper_zero: assert property (
		@(posedge ref_clk) disable iff (any_reset)
		commit && !st.wr && st.addr == `TR_CTL_OFF |=> (hrdata >> (`TR_TEST_BIT + 1)) == `TR_WORD_ZERO
	) else $error("control read upper bits not zero");

	chk_tin_upper_zero: assert property (
		@(posedge ref_clk) disable iff (any_reset)
		commit && !st.wr && st.addr == `TR_TIN_OFF |=> (hrdata >> (`TR_TIN_MSB + 1)) == `TR_WORD_ZERO
	) else $error("input register upper bits not zero");

	chk_tout_upper_zero: assert property (
		@(posedge ref_clk) disable iff (any_reset)
		commit && !st.wr && st.addr == `TR_TOUT_OFF |=> (hrdata >> (`TR_TOUT_MSB + 1)) == `TR_WORD_ZERO
	) else $error("output register upper bits not zero");

	chk_tout_read_value: assert property (
		@(posedge ref_clk) disable iff (any_reset)
		commit && !st.wr && st.addr == `TR_TOUT_OFF |=> hrdata[`TR_TOUT_MSB:0] == $past(pins_out)
	) else $error("output register read returned wrong value");

	chk_tout_write_blocked: assert property (
		@(posedge ref_clk) disable iff (any_reset)
		commit && st.wr && !st.test && st.addr == `TR_TOUT_OFF |=> $stable(st.tout)
	) else $error("output register changed outside test");

	chk_core_in_test: assert property (
		@(posedge ref_clk) disable iff (any_reset)
		test_mode |-> core_in == st.tin
	) else $error("core does not see stored inputs in test");

	chk_pins_out_test: assert property (
		@(posedge ref_clk) disable iff (any_reset)
		test_mode |-> pins_out == st.tout
	) else $error("output pins not driven from register in test");

	// Stored values only move on a completed write
	chk_tin_idle_hold: assert property (
		@(posedge ref_clk) disable iff (any_reset)
		st.phase == test_regs_pkg::PH_IDLE |=> $stable(st.tin)
	) else $error("input register changed with no access");

	chk_tout_idle_hold: assert property (
		@(posedge ref_clk) disable iff (any_reset)
		st.phase == test_regs_pkg::PH_IDLE |=> $stable(st.tout)
	) else $error("output register changed with no access");

	chk_read_keeps_regs: assert property (
		@(posedge ref_clk) disable iff (any_reset)
		commit && !st.wr |=> $stable(st.tin) && $stable(st.tout) && $stable(test_mode)
	) else $error("read disturbed a test register");

	chk_tout_write_keeps_tin: assert property (
		@(posedge ref_clk) disable iff (any_reset)
		commit && st.wr && st.addr == `TR_TOUT_OFF |=> $stable(st.tin) && $stable(test_mode)
	) else $error("output register write reached another register");

	chk_unmapped_write_ignored: assert property (
		@(posedge ref_clk) disable iff (any_reset)
		(commit && st.wr && st.addr != `TR_CTL_OFF
		&& st.addr != `TR_TIN_OFF && st.addr != `TR_TOUT_OFF)
		|=> $stable(st.tin) && $stable(st.tout) && $stable(test_mode)
	) else $error("unmapped write changed a register");

endmodule : test_regs
`default_nettype wire

// ===== test_regs_master.sv
// Bus master model issuing single test register transfers
`timescale 1ns/1ps
`default_nettype none
module test_regs_master (
	input  wire logic        ref_clk,
	input  wire logic        hready_out,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [31:0]      haddr,
	output logic [31:0]      hwdata
);
	initial begin
		hsel = 1'b0;
		htrans = 2'h0;
		hwrite = 1'b0;
		haddr = 32'h0;
		hwdata = 32'h0;
	end
	// Called just after an edge with the bus idle; w counts wait cycles, capped so a hang ends
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output int w);
		w = 0;
		hsel = 1'b1;
		htrans = 2'h2;
		hwrite = wr;
		haddr = {20'h0, a};
		@(posedge ref_clk);
		#1;
		hsel = 1'b0;
		htrans = 2'h0;
		haddr = ~haddr;
		hwdata = d;
		while (hready_out !== 1'b1 && w < 8) begin
			@(posedge ref_clk);
			#1;
			w++;
		end
		@(posedge ref_clk);
		q = hrdata;
		#1;
		// Released data must not keep looking valid
		hwdata = ~d;
	endtask : xfer
endmodule : test_regs_master
`default_nettype wire

// ===== test_regs_tb_top.sv
// Self-checking testbench of the integration-test registers
`include "test_regs_defines.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
	$display("Error %s expected %0h seen %0h", n, e, g); end end
module test_regs_tb_top;
	logic                     ref_clk, rst_n, power_on_reset_n, hsel, hwrite, hready_out;
	logic [1:0]               htrans, hresp;
	logic [31:0]              haddr, hwdata, hrdata;
	logic                     test_mode;
	test_regs_pkg::test_in_s  pins_in, core_in;
	test_regs_pkg::test_out_s core_out, pins_out;
	int                       checked = 0;
	int                       miscompares = 0;
	test_regs u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .power_on_reset_n(power_on_reset_n),
		.hsel(hsel), .htrans(htrans), .hwrite(hwrite), .haddr(haddr), .hwdata(hwdata),
		.hready_in(hready_out), .hrdata(hrdata), .hready_out(hready_out), .hresp(hresp),
		.pins_in(pins_in), .core_in(core_in), .core_out(core_out), .pins_out(pins_out),
		.test_mode(test_mode));
	test_regs_master u_master (.ref_clk(ref_clk), .hready_out(hready_out), .hrdata(hrdata),
		.hsel(hsel), .htrans(htrans), .hwrite(hwrite), .haddr(haddr), .hwdata(hwdata));
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	task automatic conclude();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude
	task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int w;
		u_master.xfer(wr, a, d, q, w);
		`CHK("wait states", 1, w)
		`CHK("hresp", 2'h0, hresp)
		if (w >= 8) conclude();
	endtask : acc
	task automatic t_reset();
		logic [31:0] q;
		acc(1'b0, `TR_CTL_OFF, 32'h0, q);
		`CHK("ctl reset", 32'h0, q)
		acc(1'b0, `TR_TIN_OFF, 32'h0, q);
		`CHK("tin live", {22'h0, pins_in}, q)
		`CHK("core_in live", pins_in, core_in)
		$display("t_reset done");
	endtask : t_reset
	task automatic t_normal();
		logic [31:0] q;
		acc(1'b1, `TR_TIN_OFF, 32'h3FF, q);
		acc(1'b1, `TR_TOUT_OFF, 32'h3, q);
		`CHK("pins_out normal", core_out, pins_out)
		acc(1'b0, `TR_TOUT_OFF, 32'h0, q);
		`CHK("tout live", 32'h1, q)
		pins_in = 10'h0A5;
		acc(1'b0, `TR_TIN_OFF, 32'h0, q);
		`CHK("tin pins", 32'h0A5, q)
		$display("t_normal done");
	endtask : t_normal
	task automatic t_test();
		logic [31:0] q;
		acc(1'b1, `TR_CTL_OFF, 32'h1, q);
		`CHK("test_mode", 1'b1, test_mode)
		`CHK("tin kept", 10'h000, core_in)
		`CHK("tout kept", 2'h0, pins_out)
		acc(1'b0, `TR_CTL_OFF, 32'h0, q);
		`CHK("ctl read", 32'h1, q)
		acc(1'b1, `TR_TIN_OFF, 32'h2A5, q);
		`CHK("legacy", 1'b1, core_in.legacy_revision_config_in)
		`CHK("cs3 pol", 1'b1, core_in.cs3_polarity_in)
		`CHK("width", 2'h1, core_in.cs1_memory_width_in)
		acc(1'b0, `TR_TIN_OFF, 32'h0, q);
		`CHK("tin stored", 32'h2A5, q)
		acc(1'b1, `TR_TOUT_OFF, 32'h2, q);
		`CHK("pins_out test", 2'h2, pins_out)
		acc(1'b0, `TR_TOUT_OFF, 32'h0, q);
		`CHK("tout read", 32'h2, q)
		acc(1'b0, 12'hF60, 32'h0, q);
		`CHK("unmapped", 32'h0, q)
		acc(1'b1, `TR_CTL_OFF, 32'h0, q);
		`CHK("core_in back", pins_in, core_in)
		`CHK("pins_out back", core_out, pins_out)
		$display("t_test done");
	endtask : t_test
	task automatic t_por();
		logic [31:0] q;
		acc(1'b1, `TR_CTL_OFF, 32'h1, q);
		power_on_reset_n = 1'b0;
		@(posedge ref_clk);
		#1;
		power_on_reset_n = 1'b1;
		`CHK("por clears", 1'b0, test_mode)
		$display("t_por done");
	endtask : t_por
	initial begin
		rst_n = 1'b0;
		power_on_reset_n = 1'b1;
		pins_in = 10'h15A;
		core_out = 2'h1;
		repeat (4) @(posedge ref_clk);
		#1;
		rst_n = 1'b1;
		t_reset();
		t_normal();
		t_test();
		t_por();
		conclude();
	end
endmodule : test_regs_tb_top
`default_nettype wire
